// file: design/bramp_pkg.sv
// Overview of operation
// - In register mode a set/reset loads the set/reset value into the output register, which acts as a pipeline stage apart from the array.
// - In register mode the array stays readable and writable whatever the output register clock enable or the set/reset do.
// - In register mode a word caught in the array output stage reaches the data output one cycle later through the output register.
// - With the output register in use, read and write-through data reach the output one cycle later than in latch mode.
// - An enabled edge without write shows the addressed word on the output and leaves the array unchanged.
// - An enabled edge with write stores the input data at the address, and in write-first mode also shows it on the output.
// - In latch mode a set/reset sampled high at an enabled edge loads the set/reset value into the output latches, shown after that edge.
// - In latch mode a set/reset leaves the array untouched and ignores the address and input data of that edge.
// - With the enable low at an edge the port does no write, no read and, in latch mode, no set/reset.
// - Disabled edges keep both the array and the output latches, so in latch mode the output holds its value.
// - The set/reset is active high and sampled only at the rising clock edge, asserted for each edge to be forced.
// - Each port has a write collision policy: new data first by default, old data first, or output unchanged.
// - The output pipeline selection is 0 for no output register, the default, or 1 for one register stage.
// - The output register has its own clock enable which gates its updates.
`default_nettype none
package bramp_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0]  BRAMP_OFS_CTRL    = 8'h00;
  localparam logic [7:0]  BRAMP_OFS_SET_RESET_VALUE   = 8'h04;
  localparam logic [7:0]  BRAMP_OFS_DOUT    = 8'h08;
  localparam logic [7:0]  BRAMP_OFS_RDCNT   = 8'h0C;
  localparam logic [7:0]  BRAMP_OFS_WRCNT   = 8'h10;
  localparam logic [7:0]  BRAMP_OFS_SRCNT   = 8'h14;

  // ****************************************************************
  // Control fields and reset values
  // ****************************************************************
  localparam int          BRAMP_CTRL_WM_LSB = 0;
  localparam int          BRAMP_CTRL_PIPE   = 2;
  localparam logic [1:0]  BRAMP_WM_RST      = 2'h0;
  localparam logic        BRAMP_PIPE_RST    = 1'h0;
  localparam logic [31:0] BRAMP_SET_RESET_VALUE_RST   = 32'h00000000;
  localparam logic [31:0] BRAMP_OUT_RST     = 32'h00000000;
  localparam logic [31:0] BRAMP_CNT_RST     = 32'h00000000;
  localparam logic [31:0] BRAMP_CNT_ONE     = 32'h00000001;

  typedef enum logic [1:0] {
    BRAMP_WRITE_FIRST = 2'b00,
    BRAMP_READ_FIRST  = 2'b01,
    BRAMP_NO_CHANGE   = 2'b10
  } bramp_wmode_e;

  typedef struct packed {
    bramp_wmode_e wmode;
    logic         pipe_sel;
  } bramp_cfg_s;

endpackage
`default_nettype wire

// file: design/bramp_mem.sv
`default_nettype none
module bramp_mem #(
  parameter int DW = 32,
  parameter int AW = 10
) (
  input  wire logic          clk_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [DW-1:0] wdata_i,
  output logic      [DW-1:0] rdata_o
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  // Contents carry no reset, like the real array
  logic [DW-1:0] mem_ff [2**AW];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_ff[addr_i] <= wdata_i;
    end
  end

  // Read before write: the old word is visible in the write cycle
  assign rdata_o = mem_ff[addr_i];

endmodule
`default_nettype wire

// file: design/bramp_outreg.sv
`default_nettype none
module bramp_outreg #(
  parameter int DW = 32
) (
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          ce_i,
  input  wire logic          set_i,
  input  wire logic [DW-1:0] set_val_i,
  input  wire logic [DW-1:0] d_i,
  output logic      [DW-1:0] q_o
);
  import bramp_pkg::*;

  // ****************************************************************
  // Pipeline stage
  // ****************************************************************
  logic [DW-1:0] q_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_ff <= BRAMP_OUT_RST[DW-1:0];
    end else if (ce_i) begin
      if (set_i) begin
        q_ff <= set_val_i;
      end else begin
        q_ff <= d_i;
      end
    end
  end

  assign q_o = q_ff;

endmodule
`default_nettype wire

// file: design/bramp_top.sv
// The Wishbone interface to the registers and the register offsets are this design's own decisions.
`default_nettype none
module bramp_top #(
  parameter int DW = 32,
  parameter int AW = 10
) (
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // Wishbone classic slave
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire logic [7:0]    wb_adr_i,
  input  wire logic [31:0]   wb_dat_i,
  input  wire logic [3:0]    wb_sel_i,
  output logic      [31:0]   wb_dat_o,
  output logic               wb_ack_o,
  // Memory port
  input  wire logic          en_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [DW-1:0] write_data_in_i,
  input  wire logic          sync_set_reset_i,
  input  wire logic          output_reg_clock_enable_i,
  output logic      [DW-1:0] dout_o
);
  import bramp_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  bramp_cfg_s    cfg_ff;
  logic [DW-1:0] set_reset_value_ff;
  logic [DW-1:0] array_output_stage_ff;
  logic [DW-1:0] nxt_array_output_stage;
  logic [31:0]   rd_cnt_ff;
  logic [31:0]   wr_cnt_ff;
  logic [31:0]   sr_cnt_ff;
  logic          ack_ff;
  logic [31:0]   dat_ff;
  logic [31:0]   nxt_dat;
  logic [DW-1:0] mem_rdata;
  logic [DW-1:0] out_q;
  logic          mem_we;
  logic          latch_ssr;
  logic          do_read;
  logic          do_write;
  logic          bus_req;
  logic          bus_wr;
  logic          or_ce;
  logic          or_set;
  logic [DW-1:0] or_d;

  // ****************************************************************
  // Wishbone slave
  // ****************************************************************
  // One wait state: ack rises the cycle after the strobe and drops
  // the cycle after; a write commits at the edge where ack is seen.
  assign bus_req = wb_cyc_i & wb_stb_i;
  assign bus_wr  = bus_req & wb_we_i & ack_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= bus_req & ~ack_ff;
    end
  end

  always_comb begin
    nxt_dat = 32'h00000000;
    if (wb_adr_i == BRAMP_OFS_CTRL) begin
      nxt_dat[BRAMP_CTRL_WM_LSB +: 2] = cfg_ff.wmode;
      nxt_dat[BRAMP_CTRL_PIPE]        = cfg_ff.pipe_sel;
    end else if (wb_adr_i == BRAMP_OFS_SET_RESET_VALUE) begin
      nxt_dat = 32'(set_reset_value_ff);
    end else if (wb_adr_i == BRAMP_OFS_DOUT) begin
      nxt_dat = 32'(out_q);
    end else if (wb_adr_i == BRAMP_OFS_RDCNT) begin
      nxt_dat = rd_cnt_ff;
    end else if (wb_adr_i == BRAMP_OFS_WRCNT) begin
      nxt_dat = wr_cnt_ff;
    end else if (wb_adr_i == BRAMP_OFS_SRCNT) begin
      nxt_dat = sr_cnt_ff;
    end else begin
      nxt_dat = 32'h00000000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_ff <= 32'h00000000;
    end else if (bus_req & ~ack_ff) begin
      dat_ff <= nxt_dat;
    end
  end

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  // Changing the mode while the port runs is legal but the word in
  // flight follows the new mode from the next edge on.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_ff.wmode    <= bramp_wmode_e'(BRAMP_WM_RST);
      cfg_ff.pipe_sel <= BRAMP_PIPE_RST;
    end else if (bus_wr && wb_adr_i == BRAMP_OFS_CTRL && wb_sel_i[0]) begin
      case (wb_dat_i[BRAMP_CTRL_WM_LSB +: 2])
        2'b01:   cfg_ff.wmode <= BRAMP_READ_FIRST;
        2'b10:   cfg_ff.wmode <= BRAMP_NO_CHANGE;
        default: cfg_ff.wmode <= BRAMP_WRITE_FIRST;
      endcase
      cfg_ff.pipe_sel <= wb_dat_i[BRAMP_CTRL_PIPE];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      set_reset_value_ff <= BRAMP_SET_RESET_VALUE_RST[DW-1:0];
    end else if (bus_wr && wb_adr_i == BRAMP_OFS_SET_RESET_VALUE) begin
      for (int b = 0; b < DW; b++) begin
        if (wb_sel_i[b/8]) begin
          set_reset_value_ff[b] <= wb_dat_i[b];
        end
      end
    end
  end

  // ****************************************************************
  // Port operation decode
  // ****************************************************************
  // Set/reset acts on the latch only in latch mode; in register mode
  // it belongs to the output register and the array runs on.
  assign latch_ssr = en_i & sync_set_reset_i & ~cfg_ff.pipe_sel;
  assign do_write  = en_i & we_i & ~latch_ssr;
  assign do_read   = en_i & ~we_i & ~latch_ssr;
  assign mem_we    = do_write;

  bramp_mem #(
    .DW (DW),
    .AW (AW)
  ) u_mem (
    .clk_i   (clk_i),
    .we_i    (mem_we),
    .addr_i  (addr_i),
    .wdata_i (write_data_in_i),
    .rdata_o (mem_rdata)
  );

  // ****************************************************************
  // Array output stage
  // ****************************************************************
  always_comb begin
    nxt_array_output_stage = array_output_stage_ff;
    if (latch_ssr) begin
      nxt_array_output_stage = set_reset_value_ff;
    end else if (do_read) begin
      nxt_array_output_stage = mem_rdata;
    end else if (do_write) begin
      case (cfg_ff.wmode)
        BRAMP_READ_FIRST: begin
          nxt_array_output_stage = mem_rdata;
        end
        BRAMP_NO_CHANGE: begin
          nxt_array_output_stage = array_output_stage_ff;
        end
        default: begin
          nxt_array_output_stage = write_data_in_i;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      array_output_stage_ff <= BRAMP_OUT_RST[DW-1:0];
    end else begin
      array_output_stage_ff <= nxt_array_output_stage;
    end
  end

  // ****************************************************************
  // Output register
  // ****************************************************************
  // In latch mode this stage mirrors the latch, so the output always
  // leaves a flip-flop without adding a cycle.
  always_comb begin
    if (cfg_ff.pipe_sel) begin
      or_ce  = output_reg_clock_enable_i;
      or_set = sync_set_reset_i;
      or_d   = array_output_stage_ff;
    end else begin
      or_ce  = 1'b1;
      or_set = 1'b0;
      or_d   = nxt_array_output_stage;
    end
  end

  bramp_outreg #(
    .DW (DW)
  ) u_outreg (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .ce_i      (or_ce),
    .set_i     (or_set),
    .set_val_i (set_reset_value_ff),
    .d_i       (or_d),
    .q_o       (out_q)
  );

  // ****************************************************************
  // Activity counters
  // ****************************************************************
  // Any bus write to a counter clears it; a port event in the same
  // cycle still counts, so no event is lost.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_cnt_ff <= BRAMP_CNT_RST;
    end else if (bus_wr && wb_adr_i == BRAMP_OFS_RDCNT) begin
      rd_cnt_ff <= do_read ? BRAMP_CNT_ONE : BRAMP_CNT_RST;
    end else if (do_read) begin
      rd_cnt_ff <= rd_cnt_ff + BRAMP_CNT_ONE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_cnt_ff <= BRAMP_CNT_RST;
    end else if (bus_wr && wb_adr_i == BRAMP_OFS_WRCNT) begin
      wr_cnt_ff <= do_write ? BRAMP_CNT_ONE : BRAMP_CNT_RST;
    end else if (do_write) begin
      wr_cnt_ff <= wr_cnt_ff + BRAMP_CNT_ONE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sr_cnt_ff <= BRAMP_CNT_RST;
    end else if (bus_wr && wb_adr_i == BRAMP_OFS_SRCNT) begin
      sr_cnt_ff <= (or_set & or_ce) | latch_ssr ?
                   BRAMP_CNT_ONE : BRAMP_CNT_RST;
    end else if ((or_set & or_ce) | latch_ssr) begin
      sr_cnt_ff <= sr_cnt_ff + BRAMP_CNT_ONE;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
  assign dout_o   = out_q;

endmodule
`default_nettype wire

// file: tb/bramp_monitor.sv
`default_nettype none
module bramp_monitor
  import bramp_pkg::*;
#(
  parameter int DW = 32,
  parameter int AW = 10
) (
  input wire logic          clk_i,
  input wire logic          rst_i,
  input wire logic          wb_cyc_i,
  input wire logic          wb_stb_i,
  input wire logic          wb_we_i,
  input wire logic [7:0]    wb_adr_i,
  input wire logic [31:0]   wb_dat_i,
  input wire logic [3:0]    wb_sel_i,
  input wire logic [31:0]   wb_dat_o,
  input wire logic          wb_ack_o,
  input wire logic          en_i,
  input wire logic          we_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [DW-1:0] write_data_in_i,
  input wire logic          sync_set_reset_i,
  input wire logic          output_reg_clock_enable_i,
  input wire logic [DW-1:0] dout_o
);
  // ****
  // Mode tracking, only full-word SET_RESET_VALUE writes are followed
  // ****
  logic          pipe_ff;
  logic [1:0]    wm_ff;
  logic [DW-1:0] srv_ff;
  wire logic     sync_set_reset = sync_set_reset_i;
  wire logic     ce  = output_reg_clock_enable_i;
  wire logic     wra = wb_ack_o && wb_we_i && wb_cyc_i;
  wire logic     wrt = en_i && we_i && !sync_set_reset && !pipe_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pipe_ff <= BRAMP_PIPE_RST;
      wm_ff   <= BRAMP_WM_RST;
    end else if (wra && wb_adr_i == BRAMP_OFS_CTRL && wb_sel_i[0]) begin
      pipe_ff <= wb_dat_i[BRAMP_CTRL_PIPE];
      // Reserved mode 3 runs as write-first
      wm_ff   <= (&wb_dat_i[1:0]) ? 2'(BRAMP_WRITE_FIRST) : wb_dat_i[1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      srv_ff <= BRAMP_SET_RESET_VALUE_RST[DW-1:0];
    end else if (wra && wb_adr_i == BRAMP_OFS_SET_RESET_VALUE && &wb_sel_i) begin
      srv_ff <= wb_dat_i[DW-1:0];
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack late");
  property p_pulse; wb_ack_o |=> !wb_ack_o;
  endproperty
  a_pulse: assert property (p_pulse) else $error("ack too long");
  property p_dis; !pipe_ff && !en_i |=> $stable(dout_o);
  endproperty
  a_dis: assert property (p_dis) else $error("dout moved");
  property p_wf; wrt && wm_ff == BRAMP_WRITE_FIRST
    |=> dout_o == $past(write_data_in_i); endproperty
  a_wf: assert property (p_wf) else $error("no write-through");
  property p_nc; wrt && wm_ff == BRAMP_NO_CHANGE |=> $stable(dout_o);
  endproperty
  a_nc: assert property (p_nc) else $error("dout moved");
  property p_ssr; !pipe_ff && en_i && sync_set_reset |=> dout_o == $past(srv_ff);
  endproperty
  a_ssr: assert property (p_ssr) else $error("no set value");
  property p_rssr; pipe_ff && sync_set_reset && ce |=> dout_o == $past(srv_ff);
  endproperty
  a_rssr: assert property (p_rssr) else $error("no set value");
  property p_rce; pipe_ff && !ce |=> $stable(dout_o);
  endproperty
  a_rce: assert property (p_rce) else $error("reg moved");
endmodule
bind bramp_top bramp_monitor #(.DW(DW), .AW(AW)) u_mon (.*);
`default_nettype wire

// file: tb/bramp_user_model.sv
`default_nettype none
module bramp_user_model #(
  parameter int DW = 32,
  parameter int AW = 10
) (
  input  wire logic          clk_i,
  output logic               en_o,
  output logic               we_o,
  output logic               ssr_o,
  output logic               ce_o,
  output logic      [AW-1:0] addr_o,
  output logic      [DW-1:0] data_o
);
  initial begin
    {en_o, we_o, ssr_o, ce_o} = 4'h0;
    addr_o = '0;
    data_o = '0;
  end
  // ****
  // One operation per call, lines change only after an edge
  // ****
  task automatic op(input logic en, we, sync_set_reset, ce,
                    input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk_i);
    en_o   <= en;
    we_o   <= we;
    ssr_o  <= sync_set_reset;
    ce_o   <= ce;
    addr_o <= a;
    data_o <= d;
    @(posedge clk_i);
    // Idle lines are scrambled so stale values cannot pass
    en_o   <= 1'b0;
    we_o   <= 1'b0;
    ssr_o  <= 1'b0;
    addr_o <= ~addr_o;
    data_o <= ~data_o;
  endtask
endmodule
`default_nettype wire

// file: tb/bramp_top_tb_top.sv
`default_nettype none
module bramp_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import bramp_pkg::*;
  localparam int DW = 32;
  localparam int AW = 10;
  localparam logic [31:0] SRV = 32'h00000101;
  localparam logic [31:0] A1 = 32'h0000A1A1;
  localparam logic [31:0] B2 = 32'h0000B2B2;
  typedef struct packed {
    logic          en, we, sync_set_reset;
    logic [AW-1:0] a;
    logic [DW-1:0] d, e;
  } bramp_row_s;
  bramp_row_s    rows [7];
  logic          clk_i, rst_i, cyc, stb, wwe, ack, en, we, sync_set_reset, ce;
  logic [7:0]    adr;
  logic [3:0]    sel;
  logic [31:0]   dw, dr, q;
  logic [AW-1:0] addr;
  logic [DW-1:0] wd, dout;
  int            errors, check_count;

  bramp_top #(.DW(DW), .AW(AW)) uut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(wwe), .wb_adr_i(adr),
    .wb_dat_i(dw), .wb_sel_i(sel), .wb_dat_o(dr), .wb_ack_o(ack),
    .en_i(en), .we_i(we), .addr_i(addr), .write_data_in_i(wd),
    .sync_set_reset_i(sync_set_reset), .output_reg_clock_enable_i(ce),
    .dout_o(dout));
  bramp_user_model #(.DW(DW), .AW(AW)) um (.clk_i(clk_i), .en_o(en),
    .we_o(we), .ssr_o(sync_set_reset), .ce_o(ce), .addr_o(addr), .data_o(wd));

  task automatic chk(input string n, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_i);
    {cyc, stb, wwe, sel} <= {1'b1, 1'b1, w, 4'hF};
    adr <= a;
    dw  <= d;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    r = dr;
    {cyc, stb} <= 2'b00;
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  initial begin
    #20000;
    errors++;
    print_verdict();
  end

  initial begin
    {rst_i, cyc, stb, wwe, sel, adr, dw} = {4'h8, 4'h0, 8'h00, 32'h0};
    errors = 0;
    check_count = 0;
    rows[0] = '{1'b1, 1'b1, 1'b0, 10'h001, A1, A1};
    rows[1] = '{1'b1, 1'b1, 1'b0, 10'h002, B2, B2};
    rows[2] = '{1'b1, 1'b0, 1'b0, 10'h001, 32'h0, A1};
    rows[3] = '{1'b0, 1'b0, 1'b0, 10'h002, 32'h0, A1};
    rows[4] = '{1'b1, 1'b1, 1'b1, 10'h001, 32'hFFFF, SRV};
    rows[5] = '{1'b1, 1'b0, 1'b0, 10'h001, 32'h0, A1};
    rows[6] = '{1'b0, 1'b0, 1'b1, 10'h002, 32'h0, A1};
    rst_i = 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    #1 chk("dout", BRAMP_OUT_RST, dout);
    wb(1'b0, BRAMP_OFS_CTRL, 32'h0, q);
    chk("ctrl", 32'h0, q);
    wb(1'b1, BRAMP_OFS_SET_RESET_VALUE, SRV, q);
    foreach (rows[i]) begin
      um.op(rows[i].en, rows[i].we, rows[i].sync_set_reset, 1'b1, rows[i].a, rows[i].d);
      #1 chk("dout", rows[i].e, dout);
    end
    // Mode 3 is reserved and must behave as write-first
    for (int m = 1; m < 4; m++) begin
      wb(1'b1, BRAMP_OFS_CTRL, 32'(m), q);
      um.op(1'b1, 1'b1, 1'b0, 1'b1, 10'h001, 32'h0000C0C0 + m);
      #1 chk("wmode", (m == 3) ? 32'h0000C0C3 : A1, dout);
    end
    wb(1'b1, BRAMP_OFS_CTRL, 32'h00000004, q);
    um.op(1'b0, 1'b0, 1'b1, 1'b1, 10'h3FF, 32'hFFFFFFFF);
    #1 chk("rssr", SRV, dout);
    um.op(1'b1, 1'b0, 1'b0, 1'b1, 10'h002, 32'h0);
    #1 chk("lat1", 32'h0000C0C3, dout);
    @(posedge clk_i);
    #1 chk("lat2", B2, dout);
    um.op(1'b1, 1'b0, 1'b0, 1'b0, 10'h001, 32'h0);
    @(posedge clk_i);
    #1 chk("hold", B2, dout);
    um.op(1'b1, 1'b1, 1'b1, 1'b0, 10'h003, 32'h0000D3D3);
    um.op(1'b1, 1'b0, 1'b0, 1'b1, 10'h003, 32'h0);
    @(posedge clk_i);
    #1 chk("arr", 32'h0000D3D3, dout);
    wb(1'b0, BRAMP_OFS_DOUT, 32'h0, q);
    chk("doutreg", 32'h0000D3D3, q);
    wb(1'b0, 8'hFC, 32'h0, q);
    chk("unmapped", 32'h0, q);
    // Port events so far: 5 reads, 6 writes, 2 set/resets
    wb(1'b0, BRAMP_OFS_RDCNT, 32'h0, q);
    chk("rdcnt", 32'h00000005, q);
    wb(1'b0, BRAMP_OFS_WRCNT, 32'h0, q);
    chk("wrcnt", 32'h00000006, q);
    wb(1'b0, BRAMP_OFS_SRCNT, 32'h0, q);
    chk("srcnt", 32'h00000002, q);
    wb(1'b1, BRAMP_OFS_WRCNT, 32'h0, q);
    wb(1'b0, BRAMP_OFS_WRCNT, 32'h0, q);
    chk("wrclr", 32'h0, q);
    // Reset in mid-run must clear the output and the mode
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    #1 chk("rstdout", BRAMP_OUT_RST, dout);
    wb(1'b0, BRAMP_OFS_CTRL, 32'h0, q);
    chk("rstctrl", 32'h0, q);
    print_verdict();
  end
endmodule
`default_nettype wire
